// [design/isc_pkg.sv]
`default_nettype none
package isc_pkg;

    // ***************************************************
    // register map
    // ***************************************************
    localparam logic [7:0] CFG_OFF   = 8'hD6;   // serial_slave_config
    localparam logic [7:0] SCR_OFF   = 8'hD7;   // slave_status_ctrl
    localparam logic [7:0] BUF_OFF   = 8'hCF;   // data window, reads zero here
    localparam logic [7:0] CFG_RESET = 8'h00;   // config after reset
    localparam logic [7:0] SCR_RESET = 8'h00;   // status after reset

    // ***************************************************
    // field positions
    // ***************************************************
    localparam int CFG_EN_BIT     = 0;   // enable
    localparam int CFG_RATE_LSB   = 2;   // rate field, two bits
    localparam int CFG_STOPIE_BIT = 4;   // stop_irq_enable
    localparam int CFG_BFIE_BIT   = 5;   // bus_fault_irq_enable
    localparam int CFG_SEL_BIT    = 6;   // pin_pair_select
    localparam int SCR_ADDR_BIT   = 3;   // address byte seen
    localparam int SCR_ACK_BIT    = 4;   // ack out
    localparam int SCR_STOP_BIT   = 5;   // stop seen

    // ***************************************************
    // rate codes and prescale factors
    // ***************************************************
    localparam logic [1:0] RATE_STD100 = 2'h0;
    localparam logic [1:0] RATE_FAST400 = 2'h1;
    localparam logic [1:0] RATE_STD50  = 2'h2;
    localparam logic [1:0] OSC_SEL0    = 2'h0;
    localparam logic [1:0] OSC_SEL1    = 2'h1;
    localparam logic [4:0] PRE_DIV1    = 5'h01;
    localparam logic [4:0] PRE_DIV2    = 5'h02;
    localparam logic [4:0] PRE_DIV4    = 5'h04;
    localparam logic [4:0] PRE_DIV8    = 5'h08;
    localparam logic [4:0] PRE_DIV16   = 5'h10;
    localparam logic [5:0] SPB_16      = 6'h10;   // samples per bit
    localparam logic [5:0] SPB_32      = 6'h20;
    localparam int         SETUP_SHIFT = 2;       // setup = a quarter bit
    localparam logic [3:0] BITS_ADDR   = 4'h8;    // address byte length

    // ***************************************************
    // carriers
    // ***************************************************
    typedef struct packed {
        logic       spare;
        logic       sel;
        logic       bfie;
        logic       stopie;
        logic [1:0] rate;
        logic       rsvd;
        logic       en;
    } isc_cfg_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } isc_line_t;

endpackage
`default_nettype wire

// [design/isc_sync.sv]
`timescale 1ns/1ps
`default_nettype none
module isc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);

    // ***************************************************
    // two-stage synchroniser, first stage read only here
    // ***************************************************
    logic [W-1:0] meta_q;   // first stage
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_d;

    // next values; no reset so the chain settles from the pin itself
    always_comb begin
        meta_d = ce_in ? d_in : meta_q;
        sync_d = ce_in ? meta_q : q_out;
    end

    // register stage
    always_ff @(posedge clk_in) begin
        meta_q <= meta_d;
        q_out  <= sync_d;
    end

endmodule
`default_nettype wire

// [design/isc_prescale.sv]
`timescale 1ns/1ps
`default_nettype none
module isc_prescale (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic [1:0] rate_in,
    input  wire logic [1:0] osc_in,
    output var  logic       tick_out,
    output var  logic [5:0] spb_out
);

    // ***************************************************
    // prescale factor and samples per bit
    // ***************************************************
    logic [4:0] div;     // factor from rate and oscillator setting
    logic [4:0] cnt_q;   // divider count
    logic [4:0] cnt_d;
    logic       tick_d;

    // factor table: fast code runs four times quicker
    always_comb begin
        unique case (rate_in)
            isc_pkg::RATE_STD100, isc_pkg::RATE_STD50: begin
                div = (osc_in == isc_pkg::OSC_SEL0) ? isc_pkg::PRE_DIV8 :
                      (osc_in == isc_pkg::OSC_SEL1) ? isc_pkg::PRE_DIV4 : isc_pkg::PRE_DIV16;
            end
            isc_pkg::RATE_FAST400: begin
                div = (osc_in == isc_pkg::OSC_SEL0) ? isc_pkg::PRE_DIV2 :
                      (osc_in == isc_pkg::OSC_SEL1) ? isc_pkg::PRE_DIV1 : isc_pkg::PRE_DIV4;
            end
            default: begin // reserved code, undivided
                div = isc_pkg::PRE_DIV1;
            end
        endcase
        spb_out = (rate_in == isc_pkg::RATE_STD50) ? isc_pkg::SPB_32 : isc_pkg::SPB_16;
    end

    // sample tick every div clocks, so rates follow the clock itself
    always_comb begin
        if (cnt_q >= div - 5'h01) begin
            cnt_d  = 5'h00;
            tick_d = 1'b1;
        end else begin
            cnt_d  = cnt_q + 5'h01;
            tick_d = 1'b0;
        end
    end

    // register stage
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_q    <= 5'h00;
            tick_out <= 1'b0;
        end else if (ce_in) begin
            cnt_q    <= cnt_d;
            tick_out <= tick_d;
        end
    end

endmodule
`default_nettype wire

// [design/isc_top.sv]
// Behaviour
// - select bit chooses default or alternate pins
// - stop flag rising raises interrupt if enabled
// - no new stop interrupt while flag set
// - bus fault enable bit stored, no effect
// - rate code picks 100K, 400K, 50K
// - sample rate is clock over prescale
// - 16 or 32 samples, prescale from oscillator
// - rates scale with the system clock
// - interrupt on start plus address byte
// - follow master clock, setup after stall
// - disabled holds all but config reset
// - data buffer access blocked while disabled
// - enable passes a clock synchroniser first
// - pins owned by block only when enabled
// - any start restarts address reception
// - any stop returns to idle
// - stop flag on addressed stop, firmware clears
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module isc_top (
    input  wire logic       SYS_CLK_IN,
    input  wire logic       RESETN_IN,
    input  wire logic       CE_IN,
    input  wire logic [7:0] ADDR_IN,
    input  wire logic [7:0] WR_DATA_IN,
    input  wire logic       WR_IN,
    input  wire logic       RD_IN,
    output var  logic [7:0] RD_DATA_OUT,
    input  wire logic [1:0] OSC_SEL_IN,
    input  wire logic       SCL_A_IN,
    input  wire logic       SDA_A_IN,
    input  wire logic       SCL_B_IN,
    input  wire logic       SDA_B_IN,
    output var  logic       SCL_A_OUT,
    output var  logic       SDA_A_OUT,
    output var  logic       SCL_B_OUT,
    output var  logic       SDA_B_OUT,
    output var  logic       SCL_A_OE_N_OUT,
    output var  logic       SDA_A_OE_N_OUT,
    output var  logic       SCL_B_OE_N_OUT,
    output var  logic       SDA_B_OE_N_OUT,
    output var  logic       PINS_A_OWNED_OUT,
    output var  logic       PINS_B_OWNED_OUT,
    output var  logic       IRQ_OUT
);

    // ***************************************************
    // configuration register, reset only by the chip reset
    // ***************************************************
    isc_pkg::isc_cfg_t cfg_q;   // serial_slave_config
    isc_pkg::isc_cfg_t cfg_d;
    logic              en_s;    // enable after synchroniser
    logic              core_rst;
    logic              cfg_wr;
    logic              scr_wr;

    assign cfg_wr = WR_IN && (ADDR_IN == isc_pkg::CFG_OFF);
    assign scr_wr = WR_IN && (ADDR_IN == isc_pkg::SCR_OFF);

    // config write; bus fault enable kept only for read back
    always_comb begin
        cfg_d = cfg_q;
        if (cfg_wr) begin
            cfg_d = isc_pkg::isc_cfg_t'(WR_DATA_IN);
            cfg_d.spare = 1'b0;
            cfg_d.rsvd  = 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESETN_IN) begin
            cfg_q <= isc_pkg::isc_cfg_t'(isc_pkg::CFG_RESET);
        end else if (CE_IN) begin
            cfg_q <= cfg_d;
        end
    end

    // enable is resynchronised before it reaches the core
    isc_sync #(.W(1)) u_en_sync (
        .clk_in (SYS_CLK_IN),
        .ce_in  (CE_IN),
        .d_in   (cfg_q.en),
        .q_out  (en_s)
    );

    // everything but config is held while disabled
    assign core_rst = !RESETN_IN || !en_s;

    // ***************************************************
    // pin synchronisers and pair select
    // ***************************************************
    logic [3:0]        pins_s;    // {scl_a, sda_a, scl_b, sda_b}
    isc_pkg::isc_line_t line;     // selected pair
    logic              tick;
    logic [5:0]        spb;

    isc_sync #(.W(4)) u_pin_sync (
        .clk_in (SYS_CLK_IN),
        .ce_in  (CE_IN),
        .d_in   ({SCL_A_IN, SDA_A_IN, SCL_B_IN, SDA_B_IN}),
        .q_out  (pins_s)
    );

    // select must stay put while enabled, so no glitch guard here
    assign line = cfg_q.sel ? isc_pkg::isc_line_t'(pins_s[1:0])
                            : isc_pkg::isc_line_t'(pins_s[3:2]);

    isc_prescale u_pre (
        .clk_in   (SYS_CLK_IN),
        .rst_in   (core_rst),
        .ce_in    (CE_IN),
        .rate_in  (cfg_q.rate),
        .osc_in   (OSC_SEL_IN),
        .tick_out (tick),
        .spb_out  (spb)
    );

    // ***************************************************
    // bus condition detection on sample ticks
    // ***************************************************
    isc_pkg::isc_line_t prev_q;   // line at previous tick
    isc_pkg::isc_line_t prev_d;
    logic              start_ev;
    logic              stop_ev;
    logic              scl_rise;
    logic              scl_fall;

    // start: data falls under high clock; stop: data rises
    always_comb begin
        prev_d   = tick ? line : prev_q;
        start_ev = tick && prev_q.scl && line.scl && prev_q.sda && !line.sda;
        stop_ev  = tick && prev_q.scl && line.scl && !prev_q.sda && line.sda;
        scl_rise = tick && !prev_q.scl && line.scl;
        scl_fall = tick && prev_q.scl && !line.scl;
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (core_rst) begin
            prev_q <= '1;
        end else if (CE_IN) begin
            prev_q <= prev_d;
        end
    end

    // ***************************************************
    // slave sequencer
    // ***************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_STALL,
        ST_SETUP,
        ST_ACK,
        ST_WAIT
    } isc_state_t;

    isc_state_t st_q;
    isc_state_t st_d;
    logic [3:0] bits_q;     // address bits taken
    logic [3:0] bits_d;
    logic [4:0] setup_q;    // setup ticks left
    logic [4:0] setup_d;
    logic       hold_scl_q; // stall drive
    logic       hold_scl_d;
    logic       hold_sda_q; // ack drive
    logic       hold_sda_d;
    logic       addressed_q;
    logic       addressed_d;
    logic       ack_q;      // ack out control
    logic       ack_d;
    logic       stop_q;     // stop seen flag
    logic       stop_d;
    logic       addr_q;     // address seen flag
    logic       addr_d;
    logic       addr_set;
    logic       stop_set;
    logic       irq_d;

    always_comb begin
        st_d        = st_q;
        bits_d      = bits_q;
        setup_d     = setup_q;
        hold_scl_d  = hold_scl_q;
        hold_sda_d  = hold_sda_q;
        addressed_d = addressed_q;
        addr_set    = 1'b0;
        stop_set    = 1'b0;
        if (start_ev) begin
            st_d        = ST_ADDR;
            bits_d      = 4'h0;
            hold_scl_d  = 1'b0;
            hold_sda_d  = 1'b0;
            addressed_d = 1'b0;
        end else if (stop_ev) begin
            st_d       = ST_IDLE;
            hold_scl_d = 1'b0;
            hold_sda_d = 1'b0;
            stop_set   = addressed_q;
            addressed_d = 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin // waits for a start
                end
                ST_ADDR: begin // follows the master clock, any speed
                    if (scl_rise) begin
                        bits_d = bits_q + 4'h1;
                    end else if (scl_fall && bits_q == isc_pkg::BITS_ADDR) begin
                        st_d       = ST_STALL;
                        hold_scl_d = 1'b1;
                        addr_set   = 1'b1;
                    end
                end
                ST_STALL: begin // firmware answers via status write
                    if (scr_wr) begin
                        st_d       = ST_SETUP;
                        hold_sda_d = WR_DATA_IN[isc_pkg::SCR_ACK_BIT];
                        addressed_d = WR_DATA_IN[isc_pkg::SCR_ACK_BIT];
                        setup_d    = spb[5:1] >> (isc_pkg::SETUP_SHIFT - 1);
                    end
                end
                ST_SETUP: begin // data settles before clock release
                    if (tick) begin
                        if (setup_q == 5'h00) begin
                            st_d       = ST_ACK;
                            hold_scl_d = 1'b0;
                        end else begin
                            setup_d = setup_q - 5'h01;
                        end
                    end
                end
                ST_ACK: begin // ninth clock ends, drop data drive
                    if (scl_fall) begin
                        st_d       = ST_WAIT;
                        hold_sda_d = 1'b0;
                    end
                end
                ST_WAIT: begin // data bytes pass, wait for start or stop
                end
            endcase
        end
        // sticky flags: hardware set beats a firmware clear
        stop_d = stop_set || (stop_q && !(scr_wr && !WR_DATA_IN[isc_pkg::SCR_STOP_BIT]));
        addr_d = addr_set || (addr_q && !(scr_wr && !WR_DATA_IN[isc_pkg::SCR_ADDR_BIT]));
        ack_d  = scr_wr ? WR_DATA_IN[isc_pkg::SCR_ACK_BIT] : ack_q;
        // stop interrupt only on a 0 to 1 edge of the flag
        irq_d  = addr_set || (cfg_q.stopie && stop_set && !stop_q);
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (core_rst) begin
            st_q        <= ST_IDLE;
            bits_q      <= 4'h0;
            setup_q     <= 5'h00;
            hold_scl_q  <= 1'b0;
            hold_sda_q  <= 1'b0;
            addressed_q <= 1'b0;
            ack_q       <= isc_pkg::SCR_RESET[isc_pkg::SCR_ACK_BIT];
            stop_q      <= isc_pkg::SCR_RESET[isc_pkg::SCR_STOP_BIT];
            addr_q      <= isc_pkg::SCR_RESET[isc_pkg::SCR_ADDR_BIT];
            IRQ_OUT     <= 1'b0;
        end else if (CE_IN) begin
            st_q        <= st_d;
            bits_q      <= bits_d;
            setup_q     <= setup_d;
            hold_scl_q  <= hold_scl_d;
            hold_sda_q  <= hold_sda_d;
            addressed_q <= addressed_d;
            ack_q       <= ack_d;
            stop_q      <= stop_d;
            addr_q      <= addr_d;
            IRQ_OUT     <= irq_d;
        end
    end

    // ***************************************************
    // pin drive: owned pair only, others left to gpio
    // ***************************************************
    logic [5:0] pin_d;   // {own_a, own_b, oe_n scl_a, sda_a, scl_b, sda_b}

    always_comb begin
        pin_d[5] = en_s && !cfg_q.sel;
        pin_d[4] = en_s && cfg_q.sel;
        pin_d[3] = !(pin_d[5] && hold_scl_q);
        pin_d[2] = !(pin_d[5] && hold_sda_q);
        pin_d[1] = !(pin_d[4] && hold_scl_q);
        pin_d[0] = !(pin_d[4] && hold_sda_q);
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESETN_IN) begin
            {PINS_A_OWNED_OUT, PINS_B_OWNED_OUT} <= 2'h0;
            {SCL_A_OE_N_OUT, SDA_A_OE_N_OUT, SCL_B_OE_N_OUT, SDA_B_OE_N_OUT} <= 4'hF;
        end else if (CE_IN) begin
            {PINS_A_OWNED_OUT, PINS_B_OWNED_OUT} <= pin_d[5:4];
            {SCL_A_OE_N_OUT, SDA_A_OE_N_OUT, SCL_B_OE_N_OUT, SDA_B_OE_N_OUT} <= pin_d[3:0];
        end
    end

    // open-drain: driven value is always low
    always_ff @(posedge SYS_CLK_IN) begin
        {SCL_A_OUT, SDA_A_OUT, SCL_B_OUT, SDA_B_OUT} <= 4'h0;
    end

    // ***************************************************
    // read port, data one cycle after the strobe
    // ***************************************************
    logic [7:0] rd_d;

    always_comb begin
        rd_d = 8'h00;
        if (RD_IN) begin
            unique case (ADDR_IN)
                isc_pkg::CFG_OFF: rd_d = cfg_q;
                isc_pkg::SCR_OFF: begin
                    rd_d[isc_pkg::SCR_STOP_BIT] = stop_q;
                    rd_d[isc_pkg::SCR_ACK_BIT]  = ack_q;
                    rd_d[isc_pkg::SCR_ADDR_BIT] = addr_q;
                end
                isc_pkg::BUF_OFF: rd_d = 8'h00;
                default:          rd_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (!RESETN_IN) begin
            RD_DATA_OUT <= 8'h00;
        end else if (CE_IN) begin
            RD_DATA_OUT <= rd_d;
        end
    end

    // ***************************************************
    // checks
    // ***************************************************
    AST_STOP_IRQ: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        (CE_IN && cfg_q.stopie && !stop_q && stop_d && !core_rst) |=> IRQ_OUT)
        else $error("stop edge gave no interrupt");
    AST_NO_REPEAT: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        (CE_IN && stop_q && !addr_set && !core_rst) |=> !IRQ_OUT)
        else $error("interrupt while stop flag held");
    AST_ADDR_IRQ: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        (CE_IN && st_q == ST_ADDR && st_d == ST_STALL && !core_rst) |=> (IRQ_OUT && hold_scl_q))
        else $error("address byte without interrupt");
    AST_DIS_RESET: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        (!en_s) |=> (st_q == ST_IDLE && !stop_q && !IRQ_OUT))
        else $error("state kept while disabled");
    AST_EN_SYNC: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        (CE_IN && $rose(cfg_q.en)) |-> !en_s)
        else $error("enable reached core unsynchronised");
    AST_PIN_OWN: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        (!en_s) |=> (!PINS_A_OWNED_OUT && !PINS_B_OWNED_OUT))
        else $error("pins owned while disabled");
    AST_SEL_B: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        (CE_IN && en_s && cfg_q.sel) |=> (SCL_A_OE_N_OUT && SDA_A_OE_N_OUT))
        else $error("default pair driven while alternate selected");
    AST_START: assert property (@(posedge SYS_CLK_IN) disable iff (core_rst)
        (CE_IN && start_ev) |=> (st_q == ST_ADDR && bits_q == 4'h0))
        else $error("start did not restart address");
    AST_STOP_IDLE: assert property (@(posedge SYS_CLK_IN) disable iff (core_rst)
        (CE_IN && stop_ev && !start_ev) |=> (st_q == ST_IDLE && !hold_scl_q))
        else $error("stop did not idle");
    AST_STOP_FLAG: assert property (@(posedge SYS_CLK_IN) disable iff (core_rst)
        (CE_IN && stop_ev && addressed_q) |=> stop_q[*2])
        else $error("stop flag not set or not sticky");
    AST_SETUP_HOLD: assert property (@(posedge SYS_CLK_IN) disable iff (core_rst)
        (CE_IN && st_q == ST_STALL && st_d == ST_SETUP) |=> hold_scl_q[*2])
        else $error("stall released without setup");
    AST_BUF_ZERO: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
        (CE_IN && RD_IN && ADDR_IN == isc_pkg::BUF_OFF) |=> (RD_DATA_OUT == 8'h00))
        else $error("buffer read not blocked");

endmodule
`default_nettype wire

// [dv/isc_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far-side two-wire master, open drain
// ****************************************
module isc_master_model (
    input  wire logic clk_in,
    input  wire logic scl_in,   // wired clock line
    input  wire logic sda_in,   // wired data line
    output var  logic scl_out,  // 1 = released
    output var  logic sda_out   // 1 = released
);
    // lines released until a transfer
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // one half bit, slow or prompt by hb
    task automatic half(input int hb);
        repeat (hb) @(posedge clk_in);
    endtask
    // start, address msb first, ack clock, stop
    task automatic xfer(input logic [7:0] a, input int hb, output logic ok);
        int n;
        n = 0;
        sda_out <= 1'b0;
        half(hb);
        for (int i = 7; i >= 0; i--) begin
            scl_out <= 1'b0;
            half(hb);
            sda_out <= a[i];
            half(hb);
            scl_out <= 1'b1;
            half(hb);
        end
        scl_out <= 1'b0;
        half(hb);
        sda_out <= 1'b1;
        half(hb);
        scl_out <= 1'b1;
        // slave stretches the clock; bounded so a hang ends
        while (scl_in !== 1'b1 && n < 40000) begin
            @(posedge clk_in);
            n++;
        end
        half(hb);
        ok = scl_in === 1'b1 && sda_in === 1'b0;
        scl_out <= 1'b0;
        half(hb);
        sda_out <= 1'b0;
        half(hb);
        scl_out <= 1'b1;
        half(hb);
        sda_out <= 1'b1;
        half(hb);
    endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       clk = 0, rstn = 0, wr = 0, rd = 0, sel = 0, ok;
    logic [7:0] addr = 8'h00, wdat = 8'h00, rdat, v;
    logic [1:0] osc = 2'h0, rate;
    logic       m_scl, m_sda, sa, da, sb, db, own_a, own_b, irq;
    logic       sa_oe, da_oe, sb_oe, db_oe;
    logic       sao, dao, sbo, dbo;   // open-drain values, must be low to pull
    int         bad_count = 0, compares = 0, irq_n = 0, cyc = 0;
    always #2.5 clk = ~clk;
    // wired-and lines with pull-ups; unused pair idles high
    assign sa = (sel | m_scl) & (sa_oe | sao);
    assign da = (sel | m_sda) & (da_oe | dao);
    assign sb = (~sel | m_scl) & (sb_oe | sbo);
    assign db = (~sel | m_sda) & (db_oe | dbo);
    isc_top u_dut (.SYS_CLK_IN(clk), .RESETN_IN(rstn), .CE_IN(1'b1), .ADDR_IN(addr),
        .WR_DATA_IN(wdat), .WR_IN(wr), .RD_IN(rd), .RD_DATA_OUT(rdat), .OSC_SEL_IN(osc),
        .SCL_A_IN(sa), .SDA_A_IN(da), .SCL_B_IN(sb), .SDA_B_IN(db), .SCL_A_OUT(sao),
        .SDA_A_OUT(dao), .SCL_B_OUT(sbo), .SDA_B_OUT(dbo), .SCL_A_OE_N_OUT(sa_oe),
        .SDA_A_OE_N_OUT(da_oe), .SCL_B_OE_N_OUT(sb_oe), .SDA_B_OE_N_OUT(db_oe),
        .PINS_A_OWNED_OUT(own_a), .PINS_B_OWNED_OUT(own_b), .IRQ_OUT(irq));
    isc_master_model u_mst (.clk_in(clk), .scl_in(sel ? sb : sa), .sda_in(sel ? db : da),
        .scl_out(m_scl), .sda_out(m_sda));
    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic close_out();
        $display("mismatches %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // interrupt pulse counter and hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (irq === 1'b1) irq_n <= irq_n + 1;
        if (cyc == 90000) begin
            bad_count++;
            close_out();
        end
    end
    // ****************************************
    // register bus tasks
    // ****************************************
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdat <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string w, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(w, e, rdat & m);
    endtask
    // bits 7 and 1 read back zero
    function automatic logic [7:0] exp_cfg(input logic [7:0] c);
        return c & 8'h7D;
    endfunction
    // one transfer: stall held past the master's release, ack or nack answer, stop
    task automatic run(input logic [7:0] st, input logic [7:0] scr, input int ni);
        int n0, w;
        n0 = irq_n;
        w = 0;
        fork
            u_mst.xfer(8'($urandom), 160 + $urandom % 160, ok);
            begin
                while (irq_n == n0 && w < 40000) begin
                    @(posedge clk);
                    w++;
                end
                rd_chk("stall_status", isc_pkg::SCR_OFF, 8'h28, st);
                // late answer so the master really waits on a stretched clock
                repeat (700 + $urandom % 100) @(posedge clk);
                wr_reg(isc_pkg::SCR_OFF, scr);
            end
        join
        repeat (100) @(posedge clk);
        chk("ack_release", {7'h00, scr[isc_pkg::SCR_ACK_BIT]}, {7'h00, ok});
        chk("irq_count", 8'(ni), 8'(irq_n - n0));
    endtask
    initial begin
        ok = 1'($urandom(32'h82db_c9f2));
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd_chk("cfg_reset", isc_pkg::CFG_OFF, 8'hFF, isc_pkg::CFG_RESET);
        rd_chk("scr_reset", isc_pkg::SCR_OFF, 8'hFF, isc_pkg::SCR_RESET);
        rd_chk("unmapped", 8'h40 + 8'($urandom % 64), 8'hFF, 8'h00);
        rd_chk("buffer", isc_pkg::BUF_OFF, 8'hFF, 8'h00);
        for (int s = 0; s < 2; s++) begin
            rate = 2'($urandom % 3);
            osc <= 2'($urandom % 3);
            v = (8'($urandom) & 8'hA2) | {1'b0, s[0], 2'b01, rate, 2'b00};
            wr_reg(isc_pkg::CFG_OFF, v);
            rd_chk("cfg_rw", isc_pkg::CFG_OFF, 8'hFF, exp_cfg(v));
            chk("owned_off", 8'h00, {6'h00, own_a, own_b});
            sel = s[0];
            wr_reg(isc_pkg::CFG_OFF, v | 8'h01);
            repeat (6) @(posedge clk);
            chk("owned_on", s ? 8'h01 : 8'h02, {6'h00, own_a, own_b});
            run(8'h08, 8'h00, 1);
            run(8'h08, 8'h10, 2);
            rd_chk("stop_flag", isc_pkg::SCR_OFF, 8'h20, 8'h20);
            run(8'h28, 8'h30, 1);
            wr_reg(isc_pkg::CFG_OFF, v);
            repeat (6) @(posedge clk);
            chk("owned_off", 8'h00, {6'h00, own_a, own_b});
            rd_chk("scr_cleared", isc_pkg::SCR_OFF, 8'hFF, 8'h00);
            rd_chk("cfg_kept", isc_pkg::CFG_OFF, 8'hFF, exp_cfg(v));
        end
        close_out();
    end
endmodule
`default_nettype wire
